// >>> verilog/npcd_top.sv
// Device side NOP and PACKET command decoder with APB registers
`default_nettype none
module npcd_top (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Device side inputs
  input  wire logic        i_fault,
  // Outputs
  output logic             o_irq,
  output logic             o_ovl_req,
  output logic             o_dma_data,
  output logic      [15:0] o_limit,
  output logic             o_limit_apply,
  output logic      [31:0] o_pending
);
  // ==========================================================
  // Registers
  logic [7:0]  param_reg, count_reg, adr_lo_reg, adr_mid_reg;
  logic [7:0]  adr_hi_reg, unit_reg, fail_reg, cond_reg;
  logic [4:0]  cfg_reg;
  logic [2:0]  irq_st_reg, irq_msk_reg;
  logic [7:0]  op_reg;
  logic [1:0]  cnt_reg;
  logic        fault_s1_reg, fault_s2_reg;
  npcd_pkg::npcd_state_t state_reg;
  logic        wr, rd, cmd_wr, own, is_nop, is_pkt, pkt_ok;
  logic        done, flush, pkt_go;
  logic [7:0]  sel;
  logic [31:0] rdata;
  logic [2:0]  irq_ev, irq_clr;

  assign wr     = i_psel && i_penable && i_pwrite;
  assign rd     = i_psel && i_penable && !i_pwrite;
  assign own    = unit_reg[npcd_pkg::B_DEV] ==
                  cfg_reg[npcd_pkg::C_OWN_DEV];
  assign cmd_wr = wr && i_paddr == npcd_pkg::OFS_OPCODE && own &&
                  state_reg == npcd_pkg::NPCD_IDLE;
  assign is_nop = op_reg == npcd_pkg::OP_NOP;
  assign is_pkt = op_reg == npcd_pkg::OP_PACKET;
  assign pkt_ok = is_pkt && cfg_reg[npcd_pkg::C_PKT_SET];
  assign done   = state_reg == npcd_pkg::NPCD_BUSY &&
                  cnt_reg == 2'(npcd_pkg::BUSY_CYC - 1);
  assign flush  = done && is_nop && cfg_reg[npcd_pkg::C_OVL_SET] &&
                  param_reg == npcd_pkg::SUB_FLUSH;
  assign pkt_go = done && pkt_ok;

  // ==========================================================
  // Fault pin synchroniser
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      fault_s1_reg <= 1'b0;
      fault_s2_reg <= 1'b0;
    end else begin
      fault_s1_reg <= i_fault;
      fault_s2_reg <= fault_s1_reg;
    end
  end

  // ==========================================================
  // Host written taskfile; commands never write these back
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      param_reg   <= 8'h00;
      count_reg   <= 8'h00;
      adr_lo_reg  <= 8'h00;
      adr_mid_reg <= 8'h00;
      adr_hi_reg  <= 8'h00;
      unit_reg    <= 8'h00;
      cfg_reg     <= 5'h00;
      irq_msk_reg <= 3'h0;
    end else if (wr && state_reg == npcd_pkg::NPCD_IDLE) begin
      case (i_paddr)
        npcd_pkg::OFS_PARAM:   param_reg   <= i_pwdata[7:0];
        npcd_pkg::OFS_COUNT:   count_reg   <= i_pwdata[7:0];
        npcd_pkg::OFS_ADR_LO:  adr_lo_reg  <= i_pwdata[7:0];
        npcd_pkg::OFS_ADR_MID: adr_mid_reg <= i_pwdata[7:0];
        npcd_pkg::OFS_ADR_HI:  adr_hi_reg  <= i_pwdata[7:0];
        npcd_pkg::OFS_UNIT:    unit_reg    <= i_pwdata[7:0];
        npcd_pkg::OFS_CFG:     cfg_reg     <= i_pwdata[4:0];
        npcd_pkg::OFS_IRQ_MSK: irq_msk_reg <= i_pwdata[2:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Command sequencer
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_reg <= npcd_pkg::NPCD_IDLE;
      op_reg    <= 8'h00;
      cnt_reg   <= 2'h0;
    end else begin
      case (state_reg)
        npcd_pkg::NPCD_IDLE: begin
          cnt_reg <= 2'h0;
          if (cmd_wr) begin
            op_reg    <= i_pwdata[7:0];
            state_reg <= npcd_pkg::NPCD_BUSY;
          end
        end
        npcd_pkg::NPCD_BUSY: begin
          cnt_reg <= cnt_reg + 2'h1;
          if (done) begin
            state_reg <= npcd_pkg::NPCD_DONE;
          end
        end
        npcd_pkg::NPCD_DONE: state_reg <= npcd_pkg::NPCD_IDLE;
        default:             state_reg <= npcd_pkg::NPCD_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Error and status
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      fail_reg <= 8'h00;
      cond_reg <= npcd_pkg::RST_COND;
    end else if (cmd_wr) begin
      // Busy alone while the command is worked on
      cond_reg                  <= 8'h00;
      cond_reg[npcd_pkg::B_BSY] <= 1'b1;
      fail_reg                  <= 8'h00;
    end else if (done) begin
      cond_reg <= 8'h00;
      cond_reg[npcd_pkg::B_DRDY] <= 1'b1;
      cond_reg[npcd_pkg::B_DF] <= fault_s2_reg;
      if (!pkt_ok) begin
        cond_reg[npcd_pkg::B_ERR] <= 1'b1;
        fail_reg <= 8'h00 | (8'h01 << npcd_pkg::B_ABRT);
      end else begin
        cond_reg[npcd_pkg::B_DRQ] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // PACKET flags
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_ovl_req  <= 1'b0;
      o_dma_data <= 1'b0;
    end else if (pkt_go) begin
      o_ovl_req  <= param_reg[npcd_pkg::B_OVL];
      o_dma_data <= param_reg[npcd_pkg::B_DMA];
    end
  end

  npcd_limit u_limit (
    .i_mclk     (i_mclk),
    .i_rst_n    (i_rst_n),
    .i_load     (pkt_go),
    .i_has_data (cfg_reg[npcd_pkg::C_DATA]),
    .i_raw      ({adr_hi_reg, adr_mid_reg}),
    .o_limit    (o_limit),
    .o_apply    (o_limit_apply)
  );

  npcd_queue u_queue (
    .i_mclk    (i_mclk),
    .i_rst_n   (i_rst_n),
    .i_add     (pkt_go && cfg_reg[npcd_pkg::C_QUEUE]),
    .i_tag     (count_reg[7:npcd_pkg::TAG_LSB]),
    .i_flush   (flush),
    .o_pending (o_pending)
  );

  // ==========================================================
  // Interrupt events by bit position
  always_comb begin
    irq_ev                    = 3'h0;
    irq_ev[npcd_pkg::I_DONE]  = done;
    irq_ev[npcd_pkg::I_FLUSH] = flush;
    irq_ev[npcd_pkg::I_PKT]   = pkt_go;
  end
  // Only bits that the read returned are cleared, so an event
  // landing between setup and access is not lost
  assign irq_clr = (rd && i_paddr == npcd_pkg::OFS_IRQ_ST) ?
                   o_prdata[2:0] : 3'h0;

  // ==========================================================
  // Interrupts; set wins over read clear
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      irq_st_reg <= 3'h0;
      o_irq      <= 1'b0;
    end else begin
      irq_st_reg <= (irq_st_reg & ~irq_clr) | irq_ev;
      o_irq      <= |(irq_st_reg & irq_msk_reg);
    end
  end

  // ==========================================================
  // APB read; zero wait, unmapped reads zero with error
  always_comb begin
    rdata = 32'h0;
    case (i_paddr)
      npcd_pkg::OFS_COUNT:   rdata[7:0] = count_reg;
      npcd_pkg::OFS_ADR_LO:  rdata[7:0] = adr_lo_reg;
      npcd_pkg::OFS_ADR_MID: rdata[7:0] = adr_mid_reg;
      npcd_pkg::OFS_ADR_HI:  rdata[7:0] = adr_hi_reg;
      npcd_pkg::OFS_UNIT:    rdata[7:0] = unit_reg;
      npcd_pkg::OFS_FAIL:    rdata[7:0] = fail_reg;
      npcd_pkg::OFS_COND:    rdata[7:0] = cond_reg;
      npcd_pkg::OFS_CFG:     rdata[4:0] = cfg_reg;
      npcd_pkg::OFS_PKT:     rdata[1:0] = {o_ovl_req, o_dma_data};
      npcd_pkg::OFS_LIMIT:   rdata[15:0] = o_limit;
      npcd_pkg::OFS_IRQ_ST:  rdata[2:0] = irq_st_reg;
      npcd_pkg::OFS_IRQ_MSK: rdata[2:0] = irq_msk_reg;
      default:               rdata = 32'h0;
    endcase
  end

  assign sel = i_paddr;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_prdata  <= 32'h0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel && !i_penable;
      o_prdata  <= rdata;
      o_pslverr <= i_psel && !i_penable &&
                   (sel > npcd_pkg::OFS_IRQ_MSK || sel[1:0] != 2'b00);
    end
  end

  // ==========================================================
  // Checks
  // NOP never good
  property p_nop_err;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (done && is_nop) |=> cond_reg[npcd_pkg::B_ERR] &&
      !cond_reg[npcd_pkg::B_BSY];
  endproperty
  a_nop_err: assert property (p_nop_err)
    else $error("nop not aborted");
  property p_abrt;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (done && is_nop) |=> fail_reg == (8'h01 << npcd_pkg::B_ABRT);
  endproperty
  a_abrt: assert property (p_abrt)
    else $error("abort bit wrong");
  property p_stat;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (done && is_nop) |=> cond_reg[npcd_pkg::B_DRDY] &&
      !cond_reg[npcd_pkg::B_DRQ];
  endproperty
  a_stat: assert property (p_stat)
    else $error("nop status wrong");
  property p_cmpl;
    @(posedge i_mclk) disable iff (!i_rst_n)
    cmd_wr |-> ##3 (!cond_reg[npcd_pkg::B_BSY] &&
      cond_reg[npcd_pkg::B_DRDY]);
  endproperty
  a_cmpl: assert property (p_cmpl)
    else $error("command did not complete");
  property p_df;
    @(posedge i_mclk) disable iff (!i_rst_n)
    done |=> cond_reg[npcd_pkg::B_DF] == $past(fault_s2_reg);
  endproperty
  a_df: assert property (p_df)
    else $error("fault bit wrong");
  property p_keep;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (state_reg != npcd_pkg::NPCD_IDLE) |=> $stable(count_reg) &&
      $stable(adr_lo_reg) && $stable(adr_mid_reg) &&
      $stable(adr_hi_reg) && $stable(unit_reg);
  endproperty
  a_keep: assert property (p_keep)
    else $error("taskfile changed");
  property p_keepq;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (done && is_nop && param_reg != npcd_pkg::SUB_FLUSH) |=>
      $stable(o_pending);
  endproperty
  a_keepq: assert property (p_keepq)
    else $error("queue touched");
  property p_other;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (wr && i_paddr == npcd_pkg::OFS_OPCODE && !own &&
      state_reg == npcd_pkg::NPCD_IDLE) |=>
      state_reg == npcd_pkg::NPCD_IDLE;
  endproperty
  a_other: assert property (p_other)
    else $error("foreign command run");
  property p_pkt;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (done && is_pkt && !cfg_reg[npcd_pkg::C_PKT_SET]) |=>
      cond_reg[npcd_pkg::B_ERR];
  endproperty
  a_pkt: assert property (p_pkt)
    else $error("packet accepted wrongly");
  property p_pkt_ok;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (done && pkt_ok) |=> cond_reg[npcd_pkg::B_DRQ] &&
      !cond_reg[npcd_pkg::B_ERR];
  endproperty
  a_pkt_ok: assert property (p_pkt_ok)
    else $error("packet refused wrongly");
  property p_ovl;
    @(posedge i_mclk) disable iff (!i_rst_n)
    pkt_go |=> o_ovl_req == $past(param_reg[npcd_pkg::B_OVL]);
  endproperty
  a_ovl: assert property (p_ovl)
    else $error("overlap flag wrong");
  property p_sel;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (rd && i_paddr == npcd_pkg::OFS_UNIT) |=>
      o_prdata[npcd_pkg::B_DEV] == $past(unit_reg[npcd_pkg::B_DEV]);
  endproperty
  a_sel: assert property (p_sel)
    else $error("select bit wrong");
  property p_dma;
    @(posedge i_mclk) disable iff (!i_rst_n)
    pkt_go |=> o_dma_data == $past(param_reg[npcd_pkg::B_DMA]);
  endproperty
  a_dma: assert property (p_dma)
    else $error("dma flag wrong");
endmodule
`default_nettype wire

// >>> common/npcd_pkg.sv
// Package of constants and types for the NOP and PACKET command decoder
// What this block does
// - NOP always ends aborted, never good
// - NOP subcode zero flushes the queue when the config overlap bit is set
// - NOP subcodes one up keep queue
// - NOP sets abort bit two in error
// - NOP leaves the taskfile registers untouched
// - NOP clears busy, data request; sets ready, error
// - Fault bit set only on device fault
// - Select bit four names selected device
// - PACKET accepted only by packet devices
// - PACKET feature bit one requests overlap
// - PACKET feature bit zero selects DMA data
// - Tag zero to 31 captured when queuing
// - Latch sixteen bit byte count limit
// - Limit unused when the config data bit is clear
// - All ones limit treated as FFFE
`default_nettype none
package npcd_pkg;
  // ==========================================================
  // Register byte offsets on APB
  localparam logic [7:0] OFS_PARAM   = 8'h00;
  localparam logic [7:0] OFS_COUNT   = 8'h04;
  localparam logic [7:0] OFS_ADR_LO  = 8'h08;
  localparam logic [7:0] OFS_ADR_MID = 8'h0c;
  localparam logic [7:0] OFS_ADR_HI  = 8'h10;
  localparam logic [7:0] OFS_UNIT    = 8'h14;
  localparam logic [7:0] OFS_OPCODE  = 8'h18;
  localparam logic [7:0] OFS_FAIL    = 8'h1c;
  localparam logic [7:0] OFS_COND    = 8'h20;
  localparam logic [7:0] OFS_CFG     = 8'h24;
  localparam logic [7:0] OFS_PKT     = 8'h28;
  localparam logic [7:0] OFS_LIMIT   = 8'h2c;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h30;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h34;
  // ==========================================================
  // Opcodes and subcodes
  localparam logic [7:0] OP_NOP      = 8'h00;
  localparam logic [7:0] OP_PACKET   = 8'ha0;
  localparam logic [7:0] SUB_FLUSH   = 8'h00;
  // ==========================================================
  // Bit positions
  localparam int B_BSY  = 7;
  localparam int B_DRDY = 6;
  localparam int B_DF   = 5;
  localparam int B_DRQ  = 3;
  localparam int B_ERR  = 0;
  localparam int B_ABRT = 2;
  localparam int B_DEV  = 4;
  localparam int B_OVL  = 1;
  localparam int B_DMA  = 0;
  localparam int TAG_LSB = 3;
  // Configuration bits
  localparam int C_OWN_DEV = 0;
  localparam int C_PKT_SET = 1;
  localparam int C_OVL_SET = 2;
  localparam int C_QUEUE   = 3;
  localparam int C_DATA    = 4;
  // Interrupt bits
  localparam int I_DONE  = 0;
  localparam int I_FLUSH = 1;
  localparam int I_PKT   = 2;
  // ==========================================================
  // Reset value and limit mapping values
  localparam logic [7:0]  RST_COND   = 8'h40;
  localparam logic [15:0] LIMIT_ONES = 16'hffff;
  localparam logic [15:0] LIMIT_EVEN = 16'hfffe;
  // Busy time while a command is worked on
  localparam int BUSY_NS   = 100;
  localparam int CLK_NS    = 50;
  localparam int BUSY_CYC  = (BUSY_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    NPCD_IDLE = 2'b00,
    NPCD_BUSY = 2'b01,
    NPCD_DONE = 2'b10
  } npcd_state_t;
endpackage
`default_nettype wire

// >>> verilog/npcd_limit.sv
// Byte count limit interpretation for PACKET PIO data
`default_nettype none
module npcd_limit (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // Control
  input  wire logic        i_load,
  input  wire logic        i_has_data,
  input  wire logic [15:0] i_raw,
  // Result
  output logic      [15:0] o_limit,
  output logic             o_apply
);
  // ==========================================================
  // Limit latch
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_limit <= 16'h0000;
      o_apply <= 1'b0;
    end else if (i_load) begin
      o_limit <= (i_raw == npcd_pkg::LIMIT_ONES) ?
                 npcd_pkg::LIMIT_EVEN : i_raw;
      o_apply <= i_has_data;
    end
  end

  property p_ones;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_load && i_raw == 16'hffff) |=> (o_limit == 16'hfffe);
  endproperty
  a_ones: assert property (p_ones)
    else $error("all ones limit not mapped");
  property p_apply;
    @(posedge i_mclk) disable iff (!i_rst_n)
    i_load |=> (o_apply == $past(i_has_data));
  endproperty
  a_apply: assert property (p_apply)
    else $error("limit apply wrong");
endmodule
`default_nettype wire

// >>> verilog/npcd_queue.sv
// Outstanding queued command tracker for the overlapped feature set
`default_nettype none
module npcd_queue #(
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // Control
  input  wire logic        i_add,
  input  wire logic [4:0]  i_tag,
  input  wire logic        i_flush,
  // State
  output logic      [31:0] o_pending
);
  // ==========================================================
  // Pending bitmap; tag range is always 0 to 31
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_pending <= 32'h0000_0000;
    end else if (i_flush) begin
      o_pending <= 32'h0000_0000;
    end else if (i_add) begin
      o_pending[i_tag] <= 1'b1;
    end
  end

  property p_flush;
    @(posedge i_mclk) disable iff (!i_rst_n)
    i_flush |=> (o_pending == 32'h0);
  endproperty
  a_flush: assert property (p_flush)
    else $error("flush left commands");
  property p_tag;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_add && !i_flush) |=> o_pending[$past(i_tag)];
  endproperty
  a_tag: assert property (p_tag)
    else $error("tag not captured");
endmodule
`default_nettype wire

// >>> test/npcd_host_model.sv
// APB master model standing in for the host adapter
`default_nettype none
module npcd_host_model (
  // Clock
  input  wire logic        i_mclk,
  // APB master side
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic      [7:0]  o_paddr,
  output logic      [31:0] o_pwdata,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hung;
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
    hung = 1'b0;
  end
  // ======
  // One transfer; request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err);
    int n;
    n = 0;
    @(posedge i_mclk);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_mclk);
    o_penable <= 1'b1;
    @(posedge i_mclk);
    while (i_pready !== 1'b1 && n < 64) begin
      @(posedge i_mclk);
      n++;
    end
    hung = (n >= 64);
    q = i_prdata;
    err = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> test/tb_npcd_top.sv
// Self-checking bench for the NOP and PACKET command decoder
`default_nettype none
module tb_npcd_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_mclk, i_rst_n, psel, penable, pwrite;
  logic        pready, pslverr, fault, irq, ovl, dma, apply;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, pending, rdat;
  logic [15:0] limit;
  logic        rerr;
  int          bad_count, n_tests;
  logic [7:0]  ta [4] = '{npcd_pkg::OFS_COUNT, npcd_pkg::OFS_ADR_MID,
                          npcd_pkg::OFS_ADR_HI, npcd_pkg::OFS_UNIT};
  logic [7:0]  te [4];

  always #25 i_mclk = ~i_mclk;

  npcd_top uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_fault(fault), .o_irq(irq),
    .o_ovl_req(ovl), .o_dma_data(dma), .o_limit(limit),
    .o_limit_apply(apply), .o_pending(pending));

  npcd_host_model host (.i_mclk(i_mclk), .o_psel(psel),
    .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
    .o_pwdata(pwdata), .i_prdata(prdata), .i_pready(pready),
    .i_pslverr(pslverr));

  // ======
  // Reporting
  task automatic final_report();
    $display("Checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk_reg(input string nm, input logic [7:0] e,
                         input logic [31:0] g);
    n_tests++;
    if (g[7:0] !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g[7:0]);
    end
  endtask
  task automatic chk_pin(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // ======
  // Access helpers
  task automatic xf(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    host.xfer(w, a, d, rdat, rerr);
    if (host.hung === 1'b1) begin
      bad_count++;
      $display("CHECK FAILED pready exp 1 got 0");
      final_report();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xf(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    xf(1'b0, a, 32'h0);
  endtask
  task automatic tf(input logic [7:0] c, m, h, u);
    te = '{c, m, h, u};
    for (int i = 0; i < 4; i++) begin
      wr(ta[i], {24'h0, te[i]});
    end
  endtask
  // Issue a command and poll until busy drops; status left in rdat
  task automatic cmd(input logic [7:0] feat, input logic [7:0] op);
    int n;
    n = 0;
    wr(npcd_pkg::OFS_PARAM, {24'h0, feat});
    wr(npcd_pkg::OFS_OPCODE, {24'h0, op});
    rd(npcd_pkg::OFS_COND);
    while (rdat[7] !== 1'b0 && n < 20) begin
      rd(npcd_pkg::OFS_COND);
      n++;
    end
    if (n >= 20) begin
      bad_count++;
      $display("CHECK FAILED busy exp 0 got 1");
      final_report();
    end
  endtask

  // ======
  // Main sequence
  initial begin
    i_mclk = 1'b0;
    i_rst_n = 1'b0;
    fault = 1'b0;
    bad_count = 0;
    n_tests = 0;
    repeat (6) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd(npcd_pkg::OFS_COND);
    chk_reg("status", npcd_pkg::RST_COND, rdat);
    wr(npcd_pkg::OFS_CFG, 32'h1e);
    wr(npcd_pkg::OFS_IRQ_MSK, 32'h07);
    // All ones limit, tag 5, nonzero limit for a data command
    tf(8'h2b, 8'hff, 8'hff, 8'h00);
    cmd(8'h03, npcd_pkg::OP_PACKET);
    chk_reg("status", 8'h48, rdat);
    chk_pin("ovl", 1, ovl);
    chk_pin("dma", 1, dma);
    chk_pin("limit", 32'hfffe, limit);
    chk_pin("apply", 1, apply);
    chk_pin("pending", 32'h20, pending);
    chk_pin("irq", 1, irq);
    rd(npcd_pkg::OFS_IRQ_ST);
    chk_pin("irq_pkt", 1, rdat[2]);
    repeat (2) @(posedge i_mclk);
    chk_pin("irq", 0, irq);
    // Masked NOP auto poll keeps the queue
    wr(npcd_pkg::OFS_IRQ_MSK, 32'h0);
    cmd(8'h01, npcd_pkg::OP_NOP);
    chk_reg("status", 8'h41, rdat);
    chk_pin("pending", 32'h20, pending);
    rd(npcd_pkg::OFS_FAIL);
    chk_reg("error", 8'h04, rdat);
    repeat (2) @(posedge i_mclk);
    chk_pin("irq", 0, irq);
    wr(npcd_pkg::OFS_IRQ_MSK, 32'h07);
    repeat (2) @(posedge i_mclk);
    chk_pin("irq", 1, irq);
    rd(npcd_pkg::OFS_IRQ_ST);
    chk_pin("irq_done", 1, rdat[0]);
    for (int i = 0; i < 4; i++) begin
      rd(ta[i]);
      chk_reg("taskfile", te[i], rdat);
    end
    // Reserved subcode with a fault pending
    fault <= 1'b1;
    repeat (3) @(posedge i_mclk);
    cmd(8'h02, npcd_pkg::OP_NOP);
    chk_reg("status", 8'h61, rdat);
    chk_pin("pending", 32'h20, pending);
    fault <= 1'b0;
    // Odd limit is legal only because no data moves here
    wr(npcd_pkg::OFS_CFG, 32'h0e);
    tf(8'hf8, 8'h35, 8'h12, 8'h00);
    cmd(8'h00, npcd_pkg::OP_PACKET);
    chk_pin("limit", 32'h1235, limit);
    chk_pin("apply", 0, apply);
    chk_pin("ovl", 0, ovl);
    chk_pin("dma", 0, dma);
    chk_pin("pending", 32'h80000020, pending);
    // Command aimed at the other unit
    tf(8'h08, 8'h00, 8'h00, 8'h10);
    wr(npcd_pkg::OFS_OPCODE, {24'h0, npcd_pkg::OP_PACKET});
    repeat (4) @(posedge i_mclk);
    rd(npcd_pkg::OFS_COND);
    chk_reg("status", 8'h48, rdat);
    chk_pin("pending", 32'h80000020, pending);
    rd(npcd_pkg::OFS_UNIT);
    chk_reg("unit", 8'h10, rdat);
    wr(npcd_pkg::OFS_UNIT, 32'h0);
    wr(npcd_pkg::OFS_CFG, 32'h0c);
    cmd(npcd_pkg::SUB_FLUSH, npcd_pkg::OP_NOP);
    chk_reg("status", 8'h41, rdat);
    chk_pin("pending", 32'h0, pending);
    rd(npcd_pkg::OFS_IRQ_ST);
    chk_pin("irq_flush", 1, rdat[npcd_pkg::I_FLUSH]);
    // No packet command set: PACKET is refused
    cmd(8'h00, npcd_pkg::OP_PACKET);
    chk_reg("status", 8'h41, rdat);
    rd(npcd_pkg::OFS_FAIL);
    chk_reg("error", 8'h04, rdat);
    rd(8'h3c);
    chk_pin("slverr", 1, rerr);
    chk_pin("rdata", 32'h0, rdat);
    final_report();
  end
endmodule
`default_nettype wire
